// ### design/psi_start_interlock.sv
`timescale 1ns/100ps
`include "psi_map.svh"

// One axis of the start interlock: the refusal checks and the speed clamp.
// Both axes use the same gate, so the two interlocks cannot drift apart.
module psi_axis_gate (
  input wire logic common_ok,
  input wire logic start,
  input wire logic busy,
  input wire logic stop_request,
  input wire logic commenced,
  input wire logic code_pending,
  input wire logic code_flag,
  input wire logic test_mode,
  input wire logic [15:0] req_speed,
  input wire logic [15:0] speed_limit,
  output logic ok,
  output logic [15:0] cmd
);
  // Level checks that hold in every mode, then those skipped in test mode.
  always_comb begin
    ok = common_ok && start && !busy && !stop_request;
    if (!test_mode) begin
      ok = ok && !commenced;
      // Both the live input and its published flag must be clear.
      ok = ok && !code_pending && !code_flag;
    end
  end

  // A request above the limit still runs, but at the limit speed.
  always_comb begin
    cmd = (req_speed > speed_limit) ? speed_limit : req_speed;
  end
endmodule : psi_axis_gate

module psi_start_interlock (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic controller_ready_bit,
  input wire logic x_axis_stop_request,
  input wire logic y_axis_stop_request,
  input wire logic x_start,
  input wire logic y_start,
  input wire logic [15:0] x_req_speed,
  input wire logic [15:0] y_req_speed,
  input wire logic [15:0] speed_limit,
  input wire logic x_dir_neg,
  input wire logic x_move_done,
  input wire logic y_move_done,
  input wire logic x_pulse,
  input wire logic x_code_pending,
  input wire logic y_code_pending,
  input wire logic test_mode,
  input wire logic tool_break,
  input wire logic drive_ready,
  input wire logic ext_stop,
  input wire logic [9:0] buf_addr,
  input wire logic buf_rd,
  output logic [15:0] buf_rdata,
  output logic module_ready_flag,
  output logic x_axis_busy_flag,
  output logic y_axis_busy_flag,
  output logic x_axis_commenced_flag,
  output logic y_axis_commenced_flag,
  output logic x_axis_code_pending_flag,
  output logic y_axis_code_pending_flag
);
  psi_pkg::psi_state_s r;
  psi_pkg::psi_state_s next_r;
  logic [1:0] code_q;
  logic x_ok;
  logic y_ok;
  logic common_ok;
  logic [15:0] x_cmd;
  logic [15:0] y_cmd;

  // Start qualification shared by both axes.
  always_comb begin
    common_ok = drive_ready && !ext_stop && !r.break_hold;
    if (!test_mode) begin
      common_ok = common_ok && r.ready && controller_ready_bit;
    end
    common_ok = common_ok && (r.x_pos <= `PSI_POS_MAX) && !r.x_pos[31];
  end

  // Gate for the X axis, fed from the registered busy and commenced bits.
  psi_axis_gate u_x_gate (
    .common_ok(common_ok),
    .start(x_start),
    .busy(r.x_busy),
    .stop_request(x_axis_stop_request),
    .commenced(r.x_comm),
    .code_pending(x_code_pending),
    .code_flag(code_q[0]),
    .test_mode(test_mode),
    .req_speed(x_req_speed),
    .speed_limit(speed_limit),
    .ok(x_ok),
    .cmd(x_cmd)
  );

  // Gate for the Y axis; it shares the speed limit with the X axis.
  psi_axis_gate u_y_gate (
    .common_ok(common_ok),
    .start(y_start),
    .busy(r.y_busy),
    .stop_request(y_axis_stop_request),
    .commenced(r.y_comm),
    .code_pending(y_code_pending),
    .code_flag(code_q[1]),
    .test_mode(test_mode),
    .req_speed(y_req_speed),
    .speed_limit(speed_limit),
    .ok(y_ok),
    .cmd(y_cmd)
  );

  // Next-state computation for the whole block.
  always_comb begin
    next_r = r;
    next_r.ctrl_d = controller_ready_bit;
    if (controller_ready_bit && !r.ctrl_d) begin
      next_r.check_cnt = `PSI_CHECK_CYC;
      next_r.ready = 1'b0;
    end else if (r.check_cnt != 4'h0) begin
      next_r.check_cnt = r.check_cnt - 4'h1;
      next_r.ready = (r.check_cnt == 4'h1);
    end

    // A break holds every start off until both axes have come to rest.
    // The set wins over the release when both fall in one cycle.
    if (tool_break) begin
      next_r.break_hold = 1'b1;
    end else if (!r.x_busy && !r.y_busy) begin
      next_r.break_hold = 1'b0;
    end

    // Commenced follows the host's start level down, so a held start cannot restart outside test mode.
    if (!x_start) begin
      next_r.x_comm = 1'b0;
    end
    if (!y_start) begin
      next_r.y_comm = 1'b0;
    end

    // An accepted start wins over an end condition, which cannot both hold.
    // Busy ends on move done, a host stop or the external stop.
    if (x_ok) begin
      next_r.x_busy = 1'b1;
      next_r.x_comm = 1'b1;
      next_r.x_spd = x_cmd;
      next_r.x_st = psi_pkg::PSI_RUN;
    end else if (r.x_busy && (x_move_done || x_axis_stop_request || ext_stop)) begin
      next_r.x_busy = 1'b0;
      next_r.x_spd = 16'h0000;
      next_r.x_st = psi_pkg::PSI_IDLE;
    end
    if (y_ok) begin
      next_r.y_busy = 1'b1;
      next_r.y_comm = 1'b1;
      next_r.y_spd = y_cmd;
      next_r.y_st = psi_pkg::PSI_RUN;
    end else if (r.y_busy && (y_move_done || y_axis_stop_request || ext_stop)) begin
      next_r.y_busy = 1'b0;
      next_r.y_spd = 16'h0000;
      next_r.y_st = psi_pkg::PSI_IDLE;
    end

    // The live present value follows every count pulse from the pulse stage.
    if (x_pulse) begin
      next_r.x_pos = x_dir_neg ? r.x_pos - 32'h1 : r.x_pos + 32'h1;
    end
    // The buffer copy is refreshed on a fixed period, and every cycle while the axis is not busy.
    if (r.refresh_cnt == 17'h0 || !r.x_busy) begin
      next_r.refresh_cnt = 17'(`PSI_REFRESH_CYC - 1);
      next_r.x_pos_buf = r.x_pos;
    end else begin
      next_r.refresh_cnt = r.refresh_cnt - 17'h1;
    end
    // Buffer reads are answered one cycle after the request.
    case (buf_addr)
      `PSI_ADDR_X_SPEED: next_r.rdata = r.x_spd;
      `PSI_ADDR_Y_SPEED: next_r.rdata = r.y_spd;
      `PSI_ADDR_X_POS_LO: next_r.rdata = r.x_pos_buf[15:0];
      `PSI_ADDR_X_POS_HI: next_r.rdata = r.x_pos_buf[31:16];
      default: next_r.rdata = 16'h0000;
    endcase
    if (!buf_rd) begin
      next_r.rdata = r.rdata;
    end
    next_r.x_pos_dir = x_dir_neg;
  end


  // State register; power-on starts a parameter check.
  // The code-pending mirror is cleared in test mode, where the code is ignored.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r <= '0;
      r.check_cnt <= `PSI_CHECK_CYC;
      r.refresh_cnt <= 17'(`PSI_REFRESH_CYC - 1);
      code_q <= 2'b00;
    end else begin
      r <= next_r;
      code_q <= test_mode ? 2'b00 : {y_code_pending, x_code_pending};
    end
  end

  assign buf_rdata = r.rdata;
  assign module_ready_flag = r.ready;
  assign x_axis_busy_flag = r.x_busy;
  assign y_axis_busy_flag = r.y_busy;
  assign x_axis_commenced_flag = r.x_comm;
  assign y_axis_commenced_flag = r.y_comm;
  assign x_axis_code_pending_flag = code_q[0];
  assign y_axis_code_pending_flag = code_q[1];
endmodule : psi_start_interlock

// ### design/psi_map.svh
`ifndef PSI_MAP_SVH
`define PSI_MAP_SVH
`define PSI_ADDR_X_SPEED 10'h258
`define PSI_ADDR_Y_SPEED 10'h259
`define PSI_ADDR_X_POS_LO 10'h25a
`define PSI_ADDR_X_POS_HI 10'h25b
`define PSI_POS_MAX 32'h00f80000
`define PSI_REFRESH_NS 100000000
`define PSI_CLK_NS 25
`define PSI_REFRESH_CYC (`PSI_REFRESH_NS / `PSI_CLK_NS / 1000)
`define PSI_CHECK_CYC 4'h8
`endif

// ### design/psi_pkg.sv
package psi_pkg;
  typedef enum logic [1:0] {
    PSI_IDLE = 2'b00,
    PSI_RUN = 2'b01,
    PSI_HOLD = 2'b10
  } psi_axis_e;
  typedef struct packed {
    psi_axis_e x_st;
    psi_axis_e y_st;
    logic x_busy;
    logic y_busy;
    logic x_comm;
    logic y_comm;
    logic [15:0] x_spd;
    logic [15:0] y_spd;
    logic [31:0] x_pos;
    logic [31:0] x_pos_buf;
    logic [16:0] refresh_cnt;
    logic [3:0] check_cnt;
    logic ready;
    logic ctrl_d;
    logic break_hold;
    logic [15:0] rdata;
    logic x_pos_dir;
  } psi_state_s;
endpackage : psi_pkg

// ### bench/psi_chk.sv
`timescale 1ns/100ps
module psi_chk (
  input wire logic clk, rst_n, x_start, x_axis_stop_request, drive_ready, ext_stop,
  input wire logic test_mode, controller_ready_bit, module_ready_flag, x_axis_busy_flag,
  input wire logic x_axis_commenced_flag, x_axis_code_pending_flag, buf_rd,
  input wire logic [9:0] buf_addr,
  input wire logic [15:0] buf_rdata
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // A start on the X axis shows as busy rising.
  sequence s_xgo;
    $rose(x_axis_busy_flag);
  endsequence
  a_idle_start: assert property (s_xgo |-> $past(x_start && !x_axis_busy_flag))
    else $error("start taken while busy");
  a_stop_blocks: assert property (s_xgo |-> $past(!x_axis_stop_request))
    else $error("start taken during stop");
  a_drive_ok: assert property (s_xgo |-> $past(drive_ready && !ext_stop))
    else $error("start taken without drive");
  a_ready_need: assert property (!$past(test_mode) ##0 s_xgo |->
    $past(module_ready_flag && controller_ready_bit && !x_axis_commenced_flag))
    else $error("start taken without ready");
  a_code_clear: assert property (!$past(test_mode) ##0 s_xgo |->
    $past(!x_axis_code_pending_flag))
    else $error("start taken with code pending");
  a_comm_drop: assert property (x_axis_commenced_flag && !x_start |=>
    !x_axis_commenced_flag)
    else $error("commenced kept after start drop");
  a_stop_ends: assert property (x_axis_stop_request && x_axis_busy_flag |-> ##[1:2]
    !x_axis_busy_flag)
    else $error("busy kept during stop");
  a_unmapped_zero: assert property (buf_rd && buf_addr == 10'h000 |=>
    buf_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_ready_wait: assert property (rst_n && !$past(rst_n) |-> !module_ready_flag [*7])
    else $error("ready before check");
endmodule : psi_chk
bind psi_start_interlock psi_chk u_chk (.*);

// ### bench/psi_drive.sv
`timescale 1ns/100ps
module psi_drive (
  input wire logic clk,
  input wire logic x_axis_busy_flag,
  output logic x_pulse,
  output logic x_move_done
);
  logic [4:0] n;
  // Counts moving cycles; sixteen pulses, then one done pulse.
  always_ff @(posedge clk) begin
    if (!x_axis_busy_flag) n <= 5'h00;
    else if (n < 5'h11) n <= n + 5'h01;
  end
  assign x_pulse = x_axis_busy_flag && n < 5'h10;
  assign x_move_done = x_axis_busy_flag && n == 5'h10;
endmodule : psi_drive

// ### bench/psi_start_interlock_bench.sv
`timescale 1ns/100ps
module psi_start_interlock_bench;
  logic clk = 0, rst_n = 0, controller_ready_bit = 1, x_axis_stop_request = 0;
  logic y_axis_stop_request = 0, x_start = 0, y_start = 0, x_dir_neg = 0, y_move_done = 0;
  logic x_code_pending = 0, y_code_pending = 0, test_mode = 0, tool_break = 0;
  logic drive_ready = 1, ext_stop = 0, buf_rd = 0, x_pulse, x_move_done;
  logic [15:0] x_req_speed = 16'h0200, y_req_speed = 16'h0050, speed_limit = 16'h0100;
  logic [9:0] buf_addr = 10'h000;
  logic [15:0] buf_rdata;
  logic module_ready_flag, x_axis_busy_flag, y_axis_busy_flag, x_axis_commenced_flag;
  logic y_axis_commenced_flag, x_axis_code_pending_flag, y_axis_code_pending_flag;
  int miscompares = 0, compares = 0;
  psi_start_interlock u_dut (.*);
  psi_drive u_drive (.*);
  always #12.5 clk = ~clk;
  task tick(input int n); repeat (n) @(posedge clk); #1; endtask : tick
  task eq(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %0t got %h want %h", $time, g, e);
    end
  endtask : eq
  task rd(input logic [9:0] a, input logic [15:0] e);
    buf_addr = a; buf_rd = 1; tick(1); buf_rd = 0; eq(buf_rdata, e); tick(1);
  endtask : rd
  task close_out;
    if (miscompares == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out
  // Watchdog over twice the expected run.
  initial begin #220000; miscompares++; close_out; end
  // Main sequence of start and readout tests.
  initial begin
    tick(12); rst_n = 1; tick(10);
    eq(module_ready_flag, 1);
    for (int i = 0; i < 4; i++) begin
      {x_axis_stop_request, ext_stop, x_code_pending, drive_ready} = 4'h1 ^ (4'h1 << i);
      tick(2); x_start = 1; tick(3);
      eq(x_axis_busy_flag, 0);
      x_start = 0; tick(2);
    end
    {x_axis_stop_request, ext_stop, x_code_pending, drive_ready} = 4'h1;
    tick(2); x_start = 1; tick(2);
    eq({x_axis_busy_flag, x_axis_commenced_flag}, 2'b11);
    rd(10'h258, 16'h0100);
    x_start = 0; tick(2);
    eq(x_axis_commenced_flag, 0);
    tick(30); eq(x_axis_busy_flag, 0);
    rd(10'h000, 16'h0000);
    rd(10'h259, 16'h0000);
    tick(4100);
    rd(10'h25a, 16'h0010);
    rd(10'h25b, 16'h0000);
    test_mode = 1; x_code_pending = 1; x_start = 1; tick(2);
    eq(x_axis_busy_flag, 1);
    eq(x_axis_code_pending_flag, 0);
    x_start = 0; x_code_pending = 0; test_mode = 0; tick(25);
    x_start = 1; tick(2); tool_break = 1; tick(1); tool_break = 0; y_start = 1; tick(3);
    eq(y_axis_busy_flag, 0);
    x_start = 0; tick(25);
    eq(y_axis_busy_flag, 1);
    rd(10'h259, 16'h0050);
    y_start = 0; y_axis_stop_request = 1; tick(2);
    eq(y_axis_busy_flag, 0);
    y_axis_stop_request = 0; tick(2);
    x_start = 1; tick(3); x_axis_stop_request = 1; tick(3);
    eq(x_axis_busy_flag, 0);
    close_out;
  end
endmodule : psi_start_interlock_bench
